// ==== dsc_cfg.svh ====
// Purpose: constants for the dual converter serial control block
// Assumes: 50 MHz system clock, 16-bit command words
// Notes:   codes and layouts shared by the design
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_WORD_BITS     16
`define DSC_CODE_BITS     12
`define DSC_HALF_BITS     8
`define DSC_CODE_FULL     12'hFFF
`define DSC_CODE_MID      12'h800
`define DSC_CODE_ZERO     12'h000
`define DSC_CMD_IN_A      4'h0
`define DSC_CMD_OUT_A     4'h1
`define DSC_CMD_BOTH_A    4'h2
`define DSC_CMD_IN_B      4'h3
`define DSC_CMD_OUT_B     4'h4
`define DSC_CMD_BOTH_B    4'h5
`define DSC_CMD_IN_ALL    4'hC
`define DSC_CMD_BOTH_ALL  4'hD
`define DSC_CMD_ADV       4'hE
`define DSC_SUB_SEL       3'h0
`define DSC_SUB_UIO_WR    3'h4
`define DSC_SUB_UIO_RD    3'h5
`define DSC_SUB_SETTLE    3'h6
`define DSC_FAST_NS       3000
`define DSC_SLOW_NS       6000
`define DSC_CLK_MHZ       50
`define DSC_FAST_CYC      ((`DSC_FAST_NS * `DSC_CLK_MHZ) / 1000)
`define DSC_SLOW_CYC      ((`DSC_SLOW_NS * `DSC_CLK_MHZ) / 1000)
`endif

// ==== dsc_pkg.sv ====
// Purpose: types for the dual converter serial control block
// Assumes: nothing
// Notes:   user pin function codes
`default_nettype none
package dsc_pkg;
  typedef enum logic [1:0]
  {
    DSC_UIO_OFF    = 2'h0,
    DSC_UIO_RB     = 2'h1,
    DSC_UIO_CHAINF = 2'h2,
    DSC_UIO_CHAINR = 2'h3
  } dsc_uio_t;
  typedef enum logic [1:0]
  {
    DSC_IDLE  = 2'h0,
    DSC_SHIFT = 2'h1,
    DSC_DONE  = 2'h3
  } dsc_state_t;
endpackage
`default_nettype wire

// ==== dsc_top.sv ====
// Purpose: serial command decode, channel registers and user pins
// Assumes: serial pins asynchronous, sampled at 50 MHz
// Notes:   reset stands for power-on; straps caught at release
//
// Contract
// - frame-sync level at power-up picks rising or falling capture edge
// - power-up code full, zero or mid from the two level select pins
// - frame mode word starts at frame-sync fall with select low
// - select may stay low in frame mode; frame-sync delimits words
// - chain out shifts on edge opposite the capture edge
// - readback pin driven after eighth active serial edge
// - readback pin released when select rises
// - leaving a serial-out mode releases pin at end of write
// - frame mode: fall-chain on falling, others on rising edges
// - one 16-bit shift register; input and output register per channel
// - code width 12 bits, top code 4095
// - settling select fast 3us or slow 6us, set over link
// - two user pins configured by serial commands only
// - host sends 16 bits msb first, select low throughout
// - command codes load input, output or both registers
// - transfer command copies input to output per select bit
// - first frame-sync rise enters frame-sync mode
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_top
  import dsc_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET_N,
  input  wire logic        I_SCLK,
  input  wire logic        I_CS_N,
  input  wire logic        I_FSYNC_N,
  input  wire logic        I_DIN,
  input  wire logic        I_PU_HIGH,
  input  wire logic        I_PU_LOW,
  output logic [11:0]      O_CHAN_A_OUTPUT,
  output logic [11:0]      O_CHAN_B_OUTPUT,
  output logic [1:0]       O_SLOW_MODE,
  output logic [15:0]      O_SETTLE_CYCLES,
  output logic             O_USER_IO_1_O,
  output logic             O_USER_IO_1_OE_N,
  output logic             O_USER_IO_2_O,
  output logic             O_USER_IO_2_OE_N
);
  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one is read only by stage two
  // no reset: the flops track the pins through reset, so the strap level
  // is ready at release and no false edge follows it (hold reset 3+ edges)
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [3:0] s3_reg;
  always_ff @(posedge I_CLK_SYS)
  begin
    s1_reg <= {I_PU_HIGH, I_PU_LOW, I_SCLK, I_CS_N, I_FSYNC_N, I_DIN};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg[3:0];
  end
  logic sclk_rise;
  logic sclk_fall;
  logic cs_n;
  logic cs_rise;
  logic fs_fall;
  logic fs_rise;
  logic din;
  assign sclk_rise = s2_reg[3] & ~s3_reg[3];
  assign sclk_fall = ~s2_reg[3] & s3_reg[3];
  assign cs_n      = s2_reg[2];
  assign cs_rise   = s2_reg[2] & ~s3_reg[2];
  assign fs_fall   = ~s2_reg[1] & s3_reg[1];
  assign fs_rise   = s2_reg[1] & ~s3_reg[1];
  assign din       = s2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // straps caught once after release; strap_done guards reuse
  logic strap_done_reg;
  logic rise_cap_reg;
  logic frame_mode_reg;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
    begin
      strap_done_reg <= 1'b0;
      rise_cap_reg   <= 1'b1;
      frame_mode_reg <= 1'b0;
    end
    else
    begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg)
        rise_cap_reg <= s2_reg[1];
      if (strap_done_reg && fs_rise)
        frame_mode_reg <= 1'b1;
    end
  end

  // active and opposite edges follow the captured strap
  logic act_edge;
  logic opp_edge;
  assign act_edge = rise_cap_reg ? sclk_rise : sclk_fall;
  assign opp_edge = rise_cap_reg ? sclk_fall : sclk_rise;

  ////////////////////////////////////////////////////////////////////////
  // framing and the single shared shift register
  dsc_state_t state_reg;
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic        word_done;
  logic        frame_start;
  assign frame_start = frame_mode_reg ? (fs_fall & ~cs_n)
                                      : 1'b0;
  assign word_done = act_edge && (count_reg == 5'd15) &&
                     (state_reg == DSC_SHIFT);
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
    begin
      state_reg <= DSC_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end
    else
    begin
      case (state_reg)
        DSC_IDLE:
        begin
          count_reg <= 5'h00;
          if (frame_start || (!frame_mode_reg && !cs_n))
            state_reg <= DSC_SHIFT;
        end
        DSC_SHIFT:
        begin
          if (cs_rise)
            state_reg <= DSC_IDLE;
          else if (frame_start)
            count_reg <= 5'h00;
          else if (act_edge)
          begin
            shift_reg <= {shift_reg[14:0], din};
            count_reg <= count_reg + 5'd1;
            if (count_reg == 5'd15)
              state_reg <= DSC_DONE;
          end
        end
        DSC_DONE:
        begin
          // select may stay low in frame mode; wait for next frame edge
          if (cs_n || frame_start)
            state_reg <= frame_start ? DSC_SHIFT : DSC_IDLE;
          count_reg <= 5'h00;
        end
        default: state_reg <= DSC_IDLE;
      endcase
    end
  end

  // the assembled word, seen in the cycle it completes
  logic [15:0] word;
  logic [3:0]  cmd;
  logic [11:0] data;
  assign word = {shift_reg[14:0], din};
  assign cmd  = word[15:12];
  assign data = word[11:0];

  ////////////////////////////////////////////////////////////////////////
  // channel registers and command decode
  logic [11:0] in_a_reg;
  logic [11:0] in_b_reg;
  logic [11:0] out_a_reg;
  logic [11:0] out_b_reg;
  logic [11:0] pu_code;
  assign pu_code = s2_reg[5] ? `DSC_CODE_FULL :
                   (s2_reg[4] ? `DSC_CODE_ZERO : `DSC_CODE_MID);
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
    begin
      in_a_reg  <= `DSC_CODE_ZERO;
      in_b_reg  <= `DSC_CODE_ZERO;
      out_a_reg <= `DSC_CODE_ZERO;
      out_b_reg <= `DSC_CODE_ZERO;
    end
    else if (!strap_done_reg)
    begin
      in_a_reg  <= pu_code;
      in_b_reg  <= pu_code;
      out_a_reg <= pu_code;
      out_b_reg <= pu_code;
    end
    else if (word_done)
    begin
      case (cmd)
        `DSC_CMD_IN_A:     in_a_reg <= data;
        `DSC_CMD_OUT_A:    out_a_reg <= data;
        `DSC_CMD_BOTH_A:
        begin
          in_a_reg  <= data;
          out_a_reg <= data;
        end
        `DSC_CMD_IN_B:     in_b_reg <= data;
        `DSC_CMD_OUT_B:    out_b_reg <= data;
        `DSC_CMD_BOTH_B:
        begin
          in_b_reg  <= data;
          out_b_reg <= data;
        end
        `DSC_CMD_IN_ALL:
        begin
          in_a_reg <= data;
          in_b_reg <= data;
        end
        `DSC_CMD_BOTH_ALL:
        begin
          in_a_reg  <= data;
          in_b_reg  <= data;
          out_a_reg <= data;
          out_b_reg <= data;
        end
        `DSC_CMD_ADV:
        begin
          if (data[11:9] == `DSC_SUB_SEL)
          begin
            if (data[0])
              out_a_reg <= in_a_reg;
            if (data[1])
              out_b_reg <= in_b_reg;
          end
        end
        default: ;                                    // 0110..1011 and 1111 ignored
      endcase
    end
  end
  assign O_CHAN_A_OUTPUT = out_a_reg;
  assign O_CHAN_B_OUTPUT = out_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // settling mode and user pin configuration
  logic [1:0] slow_reg;
  logic [1:0] mode1_reg;
  logic [1:0] mode2_reg;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
    begin
      slow_reg   <= 2'h0;
      mode1_reg  <= DSC_UIO_OFF;
      mode2_reg  <= DSC_UIO_OFF;
    end
    else if (word_done && cmd == `DSC_CMD_ADV)
    begin
      if (data[11:9] == `DSC_SUB_SETTLE)
        slow_reg <= data[1:0];
      if (data[11:9] == `DSC_SUB_UIO_WR)
      begin
        mode1_reg <= data[5:4];
        mode2_reg <= data[7:6];
      end
    end
  end
  assign O_SLOW_MODE = slow_reg;
  assign O_SETTLE_CYCLES = slow_reg != 2'h0 ? 16'(`DSC_SLOW_CYC)
                                            : 16'(`DSC_FAST_CYC);

  ////////////////////////////////////////////////////////////////////////
  // serial out: readback drives after 8th active edge until select rises
  logic       rb_on_reg;
  logic [1:0] oe_reg;
  logic [1:0] pin_reg;
  logic       upd_rise;
  logic       upd_fall;
  logic       chain_edge;
  assign upd_rise = frame_mode_reg ? sclk_rise : opp_edge;
  assign upd_fall = frame_mode_reg ? sclk_fall : opp_edge;
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RESET_N)
      rb_on_reg <= 1'b0;
    // a new frame with select held low also ends the readback window
    else if (cs_rise || frame_start || state_reg == DSC_IDLE)
      rb_on_reg <= 1'b0;
    else if (act_edge && count_reg == 5'd7 && state_reg == DSC_SHIFT)
      rb_on_reg <= 1'b1;
  end
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_pin
      logic [1:0] m;
      assign m = (g == 0) ? mode1_reg : mode2_reg;
      always_ff @(posedge I_CLK_SYS)
      begin
        if (!I_RESET_N)
        begin
          oe_reg[g]  <= 1'b0;
          pin_reg[g] <= 1'b0;
        end
        else
        begin
          oe_reg[g] <= (m == DSC_UIO_RB)     ? rb_on_reg :
                       (m != DSC_UIO_OFF);
          if ((m == DSC_UIO_CHAINF && upd_fall) ||
              (m == DSC_UIO_CHAINR && upd_rise) ||
              (m == DSC_UIO_RB && upd_rise))
            pin_reg[g] <= shift_reg[15];
        end
      end
    end
  endgenerate
  assign O_USER_IO_1_O    = pin_reg[0];
  assign O_USER_IO_2_O    = pin_reg[1];
  assign O_USER_IO_1_OE_N = ~oe_reg[0];
  assign O_USER_IO_2_OE_N = ~oe_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence word_end_s;
    word_done && strap_done_reg;
  endsequence
  load_a_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (word_end_s and (cmd == `DSC_CMD_BOTH_A)) |=> out_a_reg == $past(data))
    else $error("channel a load failed");
  xfer_sel_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (word_end_s and (cmd == `DSC_CMD_ADV && data[11:9] == 3'h0 && !data[1]))
    |=> $stable(out_b_reg))
    else $error("transfer touched b");
  drop_part_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    state_reg == DSC_SHIFT && cs_rise |=> state_reg == DSC_IDLE)
    else $error("partial word kept");
  rb_release_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    cs_rise |=> !rb_on_reg)
    else $error("readback not released");
  rb_enable_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    rb_on_reg |-> count_reg >= 5'd8 || state_reg == DSC_DONE)
    else $error("readback too early");
  frame_on_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    strap_done_reg && fs_rise |=> frame_mode_reg)
    else $error("frame mode not entered");
  settle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    slow_reg == 2'h0 |-> O_SETTLE_CYCLES == 16'd150)
    else $error("fast settle count wrong");
  pu_code_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    !strap_done_reg ##1 1'b1 |-> out_a_reg == $past(pu_code))
    else $error("power-up code wrong");
  uio_off_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    mode1_reg == DSC_UIO_OFF |=> O_USER_IO_1_OE_N)
    else $error("pin not released");
endmodule // dsc_top
`default_nettype wire

// ==== dsc_host.sv ====
// Purpose: host side serial driver for the converter control block
// Assumes: lines move on falling edges of the system clock
// Notes:   serial clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module dsc_host
(
  input  wire logic i_clk,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_fsync_n,
  output logic      o_din
);
  // idle levels until the bench sets the straps
  initial
  begin
    o_sclk    = 1'b0;
    o_cs_n    = 1'b1;
    o_fsync_n = 1'b1;
    o_din     = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // static line levels, used for straps and a select held low
  task automatic lines(input logic sck, input logic cs, input logic fs);
    o_sclk    = sck;
    o_cs_n    = cs;
    o_fsync_n = fs;
  endtask
  // first swing away from idle is the capture edge in both strap modes
  task automatic xfer(input logic [15:0] w, input int n, input logic fall,
                      input logic dsp);
    int i;
    @(negedge i_clk);
    o_sclk = fall;
    if (dsp)
      o_fsync_n = 1'b0;
    else
      o_cs_n = 1'b0;
    for (i = 0; i < n; i++)
    begin
      o_din = w[15-i];
      repeat (4) @(negedge i_clk);
      o_sclk = ~fall;
      repeat (4) @(negedge i_clk);
      o_sclk = fall;
    end
    repeat (4) @(negedge i_clk);
    // select rises only outside frame mode, so a held-low select survives
    o_cs_n    = dsp ? o_cs_n : 1'b1;
    o_fsync_n = 1'b1;
    o_din     = ~o_din; // released line must not keep the last bit
  endtask
endmodule // dsc_host
`default_nettype wire

// ==== dual_dac_serial_control_test.sv ====
// Purpose: self-checking bench for the converter serial control block
// Assumes: serial clock period 160 ns, system clock 20 ns
// Notes:   expected codes come from the command table below
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dual_dac_serial_control_test;
  import dsc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        pu_h;
  logic        pu_l;
  wire  logic  sclk;
  wire  logic  cs_n;
  wire  logic  fs_n;
  wire  logic  din;
  logic [11:0] a_out;
  logic [11:0] b_out;
  logic [1:0]  slow;
  logic [15:0] settle;
  logic        io1;
  logic        io1_oe_n;
  logic        io2;
  logic        io2_oe_n;
  int          miscompares = 0;
  int          check_count = 0;
  int          k;
  logic [15:0] wl [10] = '{16'h0123, 16'h1456, 16'h5789, 16'h3ABC,
    16'hE002, 16'hC111, 16'hE001, 16'hD222, 16'h2333, 16'h4444};
  logic [11:0] ea [10] = '{12'h800, 12'h456, 12'h456, 12'h456, 12'h456,
    12'h456, 12'h111, 12'h222, 12'h333, 12'h333};
  logic [11:0] eb [10] = '{12'h800, 12'h800, 12'h789, 12'h789, 12'hABC,
    12'hABC, 12'hABC, 12'h222, 12'h222, 12'h444};
  //////////////////////////////////////////////////////////////////////////
  // 50 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  dsc_top DUT (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_FSYNC_N(fs_n), .I_DIN(din), .I_PU_HIGH(pu_h),
    .I_PU_LOW(pu_l), .O_CHAN_A_OUTPUT(a_out), .O_CHAN_B_OUTPUT(b_out),
    .O_SLOW_MODE(slow), .O_SETTLE_CYCLES(settle), .O_USER_IO_1_O(io1),
    .O_USER_IO_1_OE_N(io1_oe_n), .O_USER_IO_2_O(io2),
    .O_USER_IO_2_OE_N(io2_oe_n));
  dsc_host HOST (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_fsync_n(fs_n), .o_din(din));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h", $time, what, got);
      miscompares++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reset stands for power-up; straps held across the release
  task automatic power_up(input logic h, input logic l, input logic fs,
                          input logic [11:0] exp);
    @(negedge clk);
    rst_n = 1'b0;
    pu_h  = h;
    pu_l  = l;
    HOST.lines(~fs, 1'b1, fs);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(16'(a_out), 16'(exp), "power-up a");
    chk(16'(b_out), 16'(exp), "power-up b");
  endtask
  task automatic word(input logic [15:0] w, input int n, input logic fall,
                      input logic dsp);
    HOST.xfer(w, n, fall, dsp);
    repeat (4) @(negedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the roughly 80 us the sequence needs
  initial
  begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    pu_h  = 1'b0;
    pu_l  = 1'b0;
    power_up(1'b1, 1'b0, 1'b1, 12'hFFF);
    power_up(1'b0, 1'b1, 1'b1, 12'h000);
    power_up(1'b0, 1'b0, 1'b1, 12'h800);
    for (k = 0; k < 10; k++)
    begin
      word(wl[k], 16, 1'b0, 1'b0);
      chk(16'(a_out), 16'(ea[k]), "table a");
      chk(16'(b_out), 16'(eb[k]), "table b");
    end
    // unused command codes 6 to 11 must leave both channel outputs alone
    for (k = 6; k < 12; k++)
    begin
      word({k[3:0], 12'hFFF}, 16, 1'b0, 1'b0);
      chk(16'(a_out), 16'h0333, "ignored a");
      chk(16'(b_out), 16'h0444, "ignored b");
    end
    word(16'hEC01, 16, 1'b0, 1'b0);
    chk(16'(slow), 16'h0001, "slow bits");
    chk(settle, 16'(`DSC_SLOW_CYC), "slow settle");
    word(16'hEC00, 16, 1'b0, 1'b0);
    chk(settle, 16'(`DSC_FAST_CYC), "fast settle");
    word(16'h1FFF, 10, 1'b0, 1'b0);
    chk(16'(a_out), 16'h0333, "partial word");
    // readback on pin 1: idle until the eighth capture edge
    word(16'hE810, 16, 1'b0, 1'b0);
    fork
      HOST.xfer(16'hEA00, 16, 1'b0, 1'b0);
      begin
        repeat (7) @(posedge sclk);
        repeat (6) @(negedge clk);
        chk(16'(io1_oe_n), 16'h0001, "early drive");
        @(posedge sclk);
        repeat (6) @(negedge clk);
        chk(16'(io1_oe_n), 16'h0000, "no drive");
      end
    join
    repeat (6) @(negedge clk);
    chk(16'(io1_oe_n), 16'h0001, "select rise");
    // chain mode drives during traffic, leaving it releases the pin
    word(16'hE830, 16, 1'b0, 1'b0);
    fork
      HOST.xfer(16'hE830, 16, 1'b0, 1'b0);
      begin
        repeat (12) @(posedge sclk);
        chk(16'(io1_oe_n), 16'h0000, "chain drive");
        // eleven bits in, the pin shows bit 4 of the previous word
        chk(16'(io1), 16'h0001, "chain data");
        chk(16'(io2_oe_n), 16'h0001, "pin 2 idle");
        chk(16'(io2), 16'h0000, "pin 2 still");
      end
    join
    word(16'hE800, 16, 1'b0, 1'b0);
    repeat (6) @(negedge clk);
    chk(16'(io1_oe_n), 16'h0001, "chain exit");
    // frame mode: a rise enters it, select then stays low
    HOST.lines(1'b0, 1'b1, 1'b0);
    repeat (4) @(negedge clk);
    HOST.lines(1'b0, 1'b1, 1'b1);
    repeat (4) @(negedge clk);
    HOST.lines(1'b0, 1'b0, 1'b1);
    word(16'h1ABC, 16, 1'b0, 1'b1);
    chk(16'(a_out), 16'h0ABC, "frame word");
    word(16'h1BCD, 16, 1'b0, 1'b1);
    chk(16'(a_out), 16'h0BCD, "frame again");
    HOST.lines(1'b0, 1'b1, 1'b1);
    word(16'h1555, 16, 1'b0, 1'b1);
    chk(16'(a_out), 16'h0BCD, "frame deselect");
    power_up(1'b0, 1'b0, 1'b0, 12'h800);
    word(16'h1321, 16, 1'b1, 1'b0);
    chk(16'(a_out), 16'h0321, "falling capture");
    complete_run();
  end
endmodule // dual_dac_serial_control_test
`default_nettype wire
